//--- hdl/cpwm_pkg.sv
// Constants shared by the compare and PWM unit.
package cpwm_pkg;

   localparam logic [3:0] CPWM_MODE_OFF     = 4'h0;
   localparam logic [3:0] CPWM_MODE_SWINT   = 4'hA;
   localparam logic [3:0] CPWM_MODE_SPECIAL = 4'hB;
   localparam logic [1:0] CPWM_PWM_MODE_HI  = 2'h3;
   localparam int         CPWM_DUTY_LO_POS  = 4;
   localparam int         CPWM_DUTY_LO_W    = 2;
   localparam logic [7:0] CPWM_CTRL_RESET   = 8'h00;
   localparam logic [7:0] CPWM_BYTE_RESET   = 8'h00;
   localparam logic [1:0] CPWM_PS_1         = 2'h0;
   localparam logic [1:0] CPWM_PS_4         = 2'h1;
   localparam logic [3:0] CPWM_PS4_LAST     = 4'h3;
   localparam logic [3:0] CPWM_PS16_LAST    = 4'hF;

   typedef enum logic [1:0] {
      CPWM_TRG_IDLE  = 2'b00,
      CPWM_TRG_ARMED = 2'b01,
      CPWM_TRG_DONE  = 2'b11
   } cpwm_trg_e;

endpackage : cpwm_pkg

//--- hdl/cpwm_sync.sv
// Two flip-flop synchroniser for level inputs from outside the clock domain.
module cpwm_sync
   import cpwm_pkg::*;
#(
   parameter int W = 1
)(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : cpwm_sync

//--- hdl/cpwm_unit.sv
// Compare and standard PWM unit with its interval-timer compare logic.
module cpwm_unit
   import cpwm_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RESET_N,
   input  wire logic        SLEEP,
   input  wire logic        CTRL_WE,
   input  wire logic [7:0]  CTRL_WDATA,
   output      logic [7:0]  CTRL_RDATA,
   input  wire logic        DUTY_UPPER_WE,
   input  wire logic [7:0]  DUTY_UPPER_WDATA,
   output      logic [7:0]  DUTY_UPPER_RDATA,
   input  wire logic        DUTY_SHADOW_WE,
   input  wire logic [7:0]  DUTY_SHADOW_WDATA,
   output      logic [7:0]  DUTY_SHADOW_RDATA,
   input  wire logic [7:0]  PERIOD_LIMIT,
   input  wire logic [1:0]  PERIOD_PRESCALE_SEL,
   input  wire logic        PERIOD_COUNTER_ON,
   output      logic [7:0]  PERIOD_COUNT,
   output      logic        PERIOD_MATCH_PULSE,
   input  wire logic [15:0] INTERVAL_COUNT,
   input  wire logic        INTERVAL_TICK,
   input  wire logic        ADC_ENABLE,
   output      logic        EVENT_FLAG,
   input  wire logic        EVENT_FLAG_CLR,
   output      logic        INTERVAL_RESET,
   output      logic        INTERVAL_OVF_INHIBIT,
   output      logic        ADC_START,
   output      logic        SPECIAL_TRIGGER,
   input  wire logic        PIN_DIRECTION_BIT,
   input  wire logic        PORT_LATCH,
   output      logic        PIN_OUT,
   output      logic        PIN_OE_N,
   output      logic        PIN_OWNED
);

   ////////////////////////////////////////////////////////////////////////////////
   // Control and duty registers.

   logic [7:0]  ctrl_r;
   logic [7:0]  duty_upper_r;
   logic [7:0]  duty_shadow_r;
   logic [1:0]  duty_lo_latch_r;
   logic [3:0]  mode;
   logic        pwm_mode;
   logic        cmp_mode;
   logic        sleep_s;
   logic        tick_s;
   logic        period_wrap;
   logic        cmp_equal;
   logic        cmp_match;
   logic        cmp_match_d_r;

   // The timer tick and sleep come from other logic paced by a different source.
   cpwm_sync #(
      .W (2)
   ) u_sync (
      .clk   (CLOCK),
      .rst_n (RESET_N),
      .d     ({SLEEP, INTERVAL_TICK}),
      .q     ({sleep_s, tick_s})
   );

   assign mode     = ctrl_r[3:0];
   assign pwm_mode = (mode[3:2] == CPWM_PWM_MODE_HI);
   assign cmp_mode = (mode == CPWM_MODE_SWINT) || (mode == CPWM_MODE_SPECIAL);

   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         ctrl_r <= CPWM_CTRL_RESET;
      else if (CTRL_WE)
         ctrl_r <= CTRL_WDATA;
   end

   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         duty_upper_r <= CPWM_BYTE_RESET;
      else if (DUTY_UPPER_WE)
         duty_upper_r <= DUTY_UPPER_WDATA;
   end

   // The compare value is the shadow and upper pair; writes to the shadow are
   // refused while PWM owns it so the running duty cannot be disturbed.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         duty_shadow_r <= CPWM_BYTE_RESET;
      else if (pwm_mode && period_wrap)
         duty_shadow_r <= duty_upper_r;
      else if (DUTY_SHADOW_WE && !pwm_mode)
         duty_shadow_r <= DUTY_SHADOW_WDATA;
   end

   // The hidden low-bit latch loads on the same wrap so both halves swap together.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         duty_lo_latch_r <= 2'h0;
      else if (pwm_mode && period_wrap)
         duty_lo_latch_r <= ctrl_r[CPWM_DUTY_LO_POS +: CPWM_DUTY_LO_W];
   end

   assign CTRL_RDATA        = {2'h0, ctrl_r[5:0]};
   assign DUTY_UPPER_RDATA  = duty_upper_r;
   assign DUTY_SHADOW_RDATA = duty_shadow_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Period timer with prescaler. The postscaler lives elsewhere and is unused here.

   logic [7:0]  period_cnt_r;
   logic [3:0]  presc_r;
   logic [1:0]  phase_r;
   logic        presc_last;
   logic        inc;
   logic        run;
   logic [9:0]  time_base;
   logic [9:0]  duty_buf;

   // Each phase step is one oscillator period; four make one instruction cycle.
   assign run = PERIOD_COUNTER_ON && !sleep_s;

   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         phase_r <= 2'h0;
      else if (run)
         phase_r <= phase_r + 2'h1;
   end

   always_comb
   begin
      presc_last = 1'b1;
      unique case (PERIOD_PRESCALE_SEL)
         CPWM_PS_1:
            presc_last = 1'b1;
         CPWM_PS_4:
            presc_last = (presc_r == CPWM_PS4_LAST);
         2'h2, 2'h3:
            presc_last = (presc_r == CPWM_PS16_LAST);
      endcase
   end

   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         presc_r <= 4'h0;
      else if (!PERIOD_COUNTER_ON)
         presc_r <= 4'h0;
      else if (run && phase_r == 2'h3)
         presc_r <= presc_last ? 4'h0 : presc_r + 4'h1;
   end

   assign inc         = run && (phase_r == 2'h3) && presc_last;
   assign period_wrap = inc && (period_cnt_r == PERIOD_LIMIT);

   // A limit lowered below the running count lets the counter pass 255 and wrap.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         period_cnt_r <= CPWM_BYTE_RESET;
      else if (period_wrap)
         period_cnt_r <= CPWM_BYTE_RESET;
      else if (inc)
         period_cnt_r <= period_cnt_r + 8'h01;
   end

   assign PERIOD_COUNT       = period_cnt_r;
   assign PERIOD_MATCH_PULSE = period_wrap;

   ////////////////////////////////////////////////////////////////////////////////
   // PWM output. Comparison granularity is one oscillator period at 1:1, so the
   // resolution follows the period limit as log2(4(limit+1)) bits.

   always_comb
   begin
      time_base = {period_cnt_r, phase_r};
      unique case (PERIOD_PRESCALE_SEL)
         CPWM_PS_1:
            time_base = {period_cnt_r, phase_r};
         CPWM_PS_4:
            time_base = {period_cnt_r, presc_r[1:0]};
         2'h2, 2'h3:
            time_base = {period_cnt_r, presc_r[3:2]};
      endcase
   end

   assign duty_buf = {duty_shadow_r, duty_lo_latch_r};

   logic        pwm_out_r;
   logic        wrap_d_r;

   // The pin rises one cycle after the wrap, once the shadow holds the new duty.
   // The clear is registered too, so the high time stays exactly duty steps long.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         wrap_d_r <= 1'b0;
      else
         wrap_d_r <= pwm_mode && period_wrap;
   end

   // A duty larger than the period never matches, so the pin simply stays high.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         pwm_out_r <= 1'b0;
      else if (!pwm_mode)
         pwm_out_r <= 1'b0;
      else if (wrap_d_r)
         pwm_out_r <= (duty_buf != 10'h000);
      else if (run && time_base == duty_buf)
         pwm_out_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Compare and special event trigger.

   cpwm_trg_e  trg_r;
   logic       cmp_out_r;
   logic       evt_r;
   logic       adc_r;
   logic       ireset_r;
   logic       strig_r;

   assign cmp_equal = (INTERVAL_COUNT == {duty_shadow_r, duty_upper_r});
   assign cmp_match = cmp_mode && !sleep_s && cmp_equal;

   // The trigger is armed on the match and the reset is only issued if the match
   // still holds at the next interval timer tick.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         trg_r <= CPWM_TRG_IDLE;
      else
      begin
         unique case (trg_r)
            CPWM_TRG_IDLE:
               if (cmp_match && mode == CPWM_MODE_SPECIAL)
                  trg_r <= CPWM_TRG_ARMED;
            CPWM_TRG_ARMED:
               if (!cmp_match)
                  trg_r <= CPWM_TRG_IDLE;
               else if (tick_s)
                  trg_r <= CPWM_TRG_DONE;
            CPWM_TRG_DONE:
               if (!cmp_match)
                  trg_r <= CPWM_TRG_IDLE;
            default:
               trg_r <= CPWM_TRG_IDLE;
         endcase
      end
   end

   // The trigger leaves on the edge at which the match is first seen.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         strig_r <= 1'b0;
      else
         strig_r <= (trg_r == CPWM_TRG_IDLE) && cmp_match
                    && (mode == CPWM_MODE_SPECIAL);
   end

   // A disabled converter gets no start, yet the trigger and timer reset still run.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         adc_r <= 1'b0;
      else
         adc_r <= (trg_r == CPWM_TRG_IDLE) && cmp_match
                  && (mode == CPWM_MODE_SPECIAL) && ADC_ENABLE;
   end

   // The reset is only issued while the match still stands at the timer tick.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         ireset_r <= 1'b0;
      else
         ireset_r <= (trg_r == CPWM_TRG_ARMED) && cmp_match && tick_s;
   end

   // Hardware set wins over a same-cycle software clear.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         evt_r <= 1'b0;
      else if (cmp_match && !cmp_match_d_r)
         evt_r <= 1'b1;
      else if (EVENT_FLAG_CLR)
         evt_r <= 1'b0;
   end

   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         cmp_match_d_r <= 1'b0;
      else
         cmp_match_d_r <= cmp_match;
   end

   // Compare output latch; neither compare mode here drives it, and a cleared
   // control register forces it low whatever the port latch holds.
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
         cmp_out_r <= 1'b0;
      else if (mode == CPWM_MODE_OFF)
         cmp_out_r <= 1'b0;
   end

   assign EVENT_FLAG           = evt_r;
   assign SPECIAL_TRIGGER      = strig_r;
   assign ADC_START            = adc_r;
   assign INTERVAL_RESET       = ireset_r;
   assign INTERVAL_OVF_INHIBIT = ireset_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin ownership. Only PWM takes the pin; the two compare modes leave it.

   always_comb
   begin
      PIN_OWNED = pwm_mode;
      PIN_OE_N  = PIN_DIRECTION_BIT;
      if (pwm_mode)
         PIN_OUT = pwm_out_r;
      else if (mode == CPWM_MODE_OFF)
         PIN_OUT = PORT_LATCH;
      else
         PIN_OUT = cmp_out_r | PORT_LATCH;
   end

endmodule : cpwm_unit

//--- testbench/cpwm_checker.sv
// Port-level assertions for the compare and PWM unit.
module cpwm_checker
   import cpwm_pkg::*;
(
   input wire logic        CLOCK,
   input wire logic        RESET_N,
   input wire logic        SLEEP,
   input wire logic [7:0]  CTRL_RDATA,
   input wire logic [7:0]  DUTY_UPPER_RDATA,
   input wire logic [7:0]  DUTY_SHADOW_RDATA,
   input wire logic [7:0]  PERIOD_COUNT,
   input wire logic        PERIOD_MATCH_PULSE,
   input wire logic [15:0] INTERVAL_COUNT,
   input wire logic        EVENT_FLAG,
   input wire logic        INTERVAL_RESET,
   input wire logic        INTERVAL_OVF_INHIBIT,
   input wire logic        ADC_START,
   input wire logic        SPECIAL_TRIGGER,
   input wire logic        PIN_DIRECTION_BIT,
   input wire logic        PORT_LATCH,
   input wire logic        PIN_OUT,
   input wire logic        PIN_OE_N,
   input wire logic        PIN_OWNED
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   ////////////////////////////////////////////////////////////////////////////////
   AST_TRIG_MATCH: assert property (SPECIAL_TRIGGER |->
      $past(CTRL_RDATA[3:0]) == CPWM_MODE_SPECIAL
      && $past(INTERVAL_COUNT) == {$past(DUTY_SHADOW_RDATA), $past(DUTY_UPPER_RDATA)})
      else $error("trigger without a match");
   AST_TRIG_PULSE: assert property (SPECIAL_TRIGGER |=> !SPECIAL_TRIGGER)
      else $error("trigger longer than one cycle");
   AST_ADC_GATE: assert property (ADC_START |-> SPECIAL_TRIGGER)
      else $error("conversion start without trigger");
   AST_EVENT_FLAG: assert property (SPECIAL_TRIGGER |-> EVENT_FLAG)
      else $error("trigger without event flag");
   AST_OVF_INHIBIT: assert property (INTERVAL_RESET == INTERVAL_OVF_INHIBIT)
      else $error("timer reset not masking overflow");
   AST_RESET_MATCH: assert property (INTERVAL_RESET |->
      $past(INTERVAL_COUNT) == {$past(DUTY_SHADOW_RDATA), $past(DUTY_UPPER_RDATA)})
      else $error("timer reset after match vanished");
   AST_OFF_PIN: assert property (CTRL_RDATA == CPWM_CTRL_RESET |->
      PIN_OUT == PORT_LATCH && !PIN_OWNED) else $error("pin held while off");
   AST_CMP_NO_PIN: assert property (CTRL_RDATA[3:2] == 2'h2 |-> !PIN_OWNED)
      else $error("compare mode owns the pin");
   AST_PIN_DIR: assert property (PIN_OE_N == PIN_DIRECTION_BIT)
      else $error("pin enable ignores direction");
   // A wrap may legally reload the shadow, so only quiet cycles are held.
   AST_SHADOW_RO: assert property (CTRL_RDATA[3:2] == CPWM_PWM_MODE_HI
      && !PERIOD_MATCH_PULSE |=> $stable(DUTY_SHADOW_RDATA))
      else $error("shadow changed in pwm");
   AST_SLEEP_FREEZE: assert property (SLEEP [*4] |=> $stable(PERIOD_COUNT))
      else $error("counter moved in sleep");
   AST_WRAP: assert property (PERIOD_MATCH_PULSE |=> PERIOD_COUNT == 8'h00)
      else $error("counter not cleared on wrap");
   cover property (SPECIAL_TRIGGER && ADC_START);
   cover property (INTERVAL_RESET);
   cover property (PERIOD_MATCH_PULSE ##2 PIN_OUT);
endmodule : cpwm_checker

bind cpwm_unit cpwm_checker u_chk (.CLOCK, .RESET_N, .SLEEP, .CTRL_RDATA, .DUTY_UPPER_RDATA,
   .DUTY_SHADOW_RDATA, .PERIOD_COUNT, .PERIOD_MATCH_PULSE, .INTERVAL_COUNT, .EVENT_FLAG,
   .INTERVAL_RESET, .INTERVAL_OVF_INHIBIT, .ADC_START, .SPECIAL_TRIGGER, .PIN_DIRECTION_BIT,
   .PORT_LATCH, .PIN_OUT, .PIN_OE_N, .PIN_OWNED);

//--- testbench/cpwm_load.sv
// Load on the unit output pin, timing each pulse it sees.
module cpwm_load
(
   input  wire logic        clk,
   input  wire logic        pin_out,
   input  wire logic        pin_oe_n,
   output wire logic        level,
   output      logic [15:0] last_hi = 16'h0000,
   output      logic [15:0] last_per = 16'h0000
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] hi_r = 16'h0000;
   logic [15:0] per_r = 16'h0000;
   logic        prev_r = 1'b0;
   // The line has a pull-down, so a released pin reads low, never the last value.
   assign level = pin_oe_n ? 1'b0 : pin_out;
   always @(posedge clk)
   begin
      prev_r <= level;
      if (level && !prev_r)
      begin
         last_per <= per_r;
         last_hi <= hi_r;
         per_r <= 16'h0001;
         hi_r <= 16'h0001;
      end
      else
      begin
         per_r <= per_r + 16'h0001;
         hi_r <= hi_r + {15'h0000, level};
      end
   end
endmodule : cpwm_load

//--- testbench/cpwm_unit_tb.sv
// Self-checking bench for the compare and PWM unit.
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
$display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module cpwm_unit_tb;
   import cpwm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] lim; logic [1:0] ps; logic [9:0] duty;} cpwm_row_s;
   cpwm_row_s rows[6] = '{'{8'h03, 2'h0, 10'h005}, '{8'h03, 2'h1, 10'h006},
      '{8'h07, 2'h0, 10'h00A}, '{8'h07, 2'h2, 10'h003}, '{8'h07, 2'h3, 10'h01E},
      '{8'hFF, 2'h0, 10'h2BC}};
   logic CLOCK, RESET_N, SLEEP, CTRL_WE, DUTY_UPPER_WE, DUTY_SHADOW_WE, PERIOD_COUNTER_ON;
   logic INTERVAL_TICK, ADC_ENABLE, EVENT_FLAG, EVENT_FLAG_CLR, INTERVAL_RESET;
   logic INTERVAL_OVF_INHIBIT, ADC_START, SPECIAL_TRIGGER, PIN_DIRECTION_BIT, PORT_LATCH;
   logic PIN_OUT, PIN_OE_N, PIN_OWNED, PERIOD_MATCH_PULSE, lvl;
   logic [7:0] CTRL_WDATA, CTRL_RDATA, DUTY_UPPER_WDATA, DUTY_UPPER_RDATA, DUTY_SHADOW_WDATA;
   logic [7:0] DUTY_SHADOW_RDATA, PERIOD_LIMIT, PERIOD_COUNT, c8;
   logic [1:0] PERIOD_PRESCALE_SEL;
   logic [15:0] INTERVAL_COUNT, hi_t, per_t;
   int err_count = 0, compares = 0, per, pv, n, m;
   cpwm_unit dut (.CLOCK, .RESET_N, .SLEEP, .CTRL_WE, .CTRL_WDATA, .CTRL_RDATA, .DUTY_UPPER_WE,
      .DUTY_UPPER_WDATA, .DUTY_UPPER_RDATA, .DUTY_SHADOW_WE, .DUTY_SHADOW_WDATA,
      .DUTY_SHADOW_RDATA, .PERIOD_LIMIT, .PERIOD_PRESCALE_SEL, .PERIOD_COUNTER_ON, .PERIOD_COUNT,
      .PERIOD_MATCH_PULSE, .INTERVAL_COUNT, .INTERVAL_TICK, .ADC_ENABLE, .EVENT_FLAG,
      .EVENT_FLAG_CLR, .INTERVAL_RESET, .INTERVAL_OVF_INHIBIT, .ADC_START, .SPECIAL_TRIGGER,
      .PIN_DIRECTION_BIT, .PORT_LATCH, .PIN_OUT, .PIN_OE_N, .PIN_OWNED);
   cpwm_load ld (.clk(CLOCK), .pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N), .level(lvl),
      .last_hi(hi_t), .last_per(per_t));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int k);
      repeat (k) @(posedge CLOCK);
   endtask : cyc
   // Register writes: 0 control, 1 duty upper, 2 duty shadow.
   task automatic wr(input int k, input logic [7:0] d);
      @(posedge CLOCK);
      CTRL_WE <= (k == 0);
      DUTY_UPPER_WE <= (k == 1);
      DUTY_SHADOW_WE <= (k == 2);
      CTRL_WDATA <= d;
      DUTY_UPPER_WDATA <= d;
      DUTY_SHADOW_WDATA <= d;
      @(posedge CLOCK);
      {CTRL_WE, DUTY_UPPER_WE, DUTY_SHADOW_WE} <= 3'h0;
   endtask : wr
   // Sends one interval tick and counts timer resets and overflow masks that follow.
   task automatic tick();
      INTERVAL_TICK <= 1'b1;
      cyc(1);
      INTERVAL_TICK <= 1'b0;
      n = 0;
      m = 0;
      repeat (6)
      begin
         @(posedge CLOCK);
         n += (INTERVAL_RESET === 1'b1);
         m += (INTERVAL_OVF_INHIBIT === 1'b1);
      end
   endtask : tick
   task automatic end_of_test();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      CLOCK = 1'b0;
      forever #2.5 CLOCK = ~CLOCK;
   end
   initial
   begin
      cyc(20000);
      err_count++;
      end_of_test();
   end
   initial
   begin
      {RESET_N, SLEEP, CTRL_WE, DUTY_UPPER_WE, DUTY_SHADOW_WE, PERIOD_COUNTER_ON} = 6'h00;
      {INTERVAL_TICK, ADC_ENABLE, EVENT_FLAG_CLR, PORT_LATCH, PERIOD_PRESCALE_SEL} = 6'h00;
      {CTRL_WDATA, DUTY_UPPER_WDATA, DUTY_SHADOW_WDATA} = 24'h000000;
      PIN_DIRECTION_BIT = 1'b1;
      PERIOD_LIMIT = 8'h03;
      INTERVAL_COUNT = 16'hFFFF;
      cyc(10);
      RESET_N <= 1'b1;
      cyc(1);
      `CHK(CTRL_RDATA, CPWM_CTRL_RESET)
      wr(0, 8'h0C);
      PERIOD_COUNTER_ON <= 1'b1;
      for (int i = 0; i < 100 && PERIOD_MATCH_PULSE !== 1'b1; i++) cyc(1);
      PIN_DIRECTION_BIT <= 1'b0;
      // Limits only grow down the table, so the counter never runs past a new limit.
      foreach (rows[i])
      begin
         PERIOD_LIMIT <= rows[i].lim;
         PERIOD_PRESCALE_SEL <= rows[i].ps;
         wr(1, rows[i].duty[9:2]);
         wr(0, {2'h0, rows[i].duty[1:0], 4'hC});
         pv = (rows[i].ps == 2'h0) ? 1 : (rows[i].ps == 2'h1) ? 4 : 16;
         per = (int'(rows[i].lim) + 1) * 4 * pv;
         cyc(3 * per + 8);
         `CHK(per_t, 16'(per))
         `CHK(hi_t, 16'(int'(rows[i].duty) * pv))
      end
      RESET_N <= 1'b0;
      cyc(2);
      RESET_N <= 1'b1;
      PERIOD_LIMIT <= 8'h03;
      PERIOD_PRESCALE_SEL <= 2'h0;
      cyc(1);
      `CHK(PIN_OWNED, 1'b0)
      wr(1, 8'h10);
      wr(0, 8'h0C);
      cyc(40);
      n = 0;
      repeat (32) begin cyc(1); n += (lvl !== 1'b1); end
      `CHK(n, 0)
      wr(1, 8'h00);
      wr(0, 8'h0C);
      cyc(40);
      n = 0;
      repeat (32) begin cyc(1); n += (lvl !== 1'b0); end
      `CHK(n, 0)
      wr(2, 8'hAA);
      cyc(2);
      `CHK(DUTY_SHADOW_RDATA, 8'h00)
      SLEEP <= 1'b1;
      cyc(4);
      c8 = PERIOD_COUNT;
      cyc(20);
      `CHK(PERIOD_COUNT, c8)
      SLEEP <= 1'b0;
      PORT_LATCH <= 1'b1;
      wr(0, 8'h00);
      cyc(2);
      `CHK(PIN_OUT, 1'b1)
      `CHK(PIN_OWNED, 1'b0)
      wr(2, 8'h12);
      wr(1, 8'h34);
      ADC_ENABLE <= 1'b1;
      wr(0, {4'h0, CPWM_MODE_SPECIAL});
      INTERVAL_COUNT <= 16'h1234;
      cyc(2);
      `CHK(SPECIAL_TRIGGER, 1'b1)
      `CHK(ADC_START, 1'b1)
      `CHK(EVENT_FLAG, 1'b1)
      cyc(1);
      `CHK(SPECIAL_TRIGGER, 1'b0)
      tick();
      `CHK(n, 1)
      `CHK(m, 1)
      INTERVAL_COUNT <= 16'h0000;
      cyc(1);
      INTERVAL_COUNT <= 16'h1234;
      cyc(2);
      `CHK(SPECIAL_TRIGGER, 1'b1)
      wr(1, 8'h35);
      tick();
      `CHK(n, 0)
      wr(0, {4'h0, CPWM_MODE_SWINT});
      EVENT_FLAG_CLR <= 1'b1;
      cyc(1);
      EVENT_FLAG_CLR <= 1'b0;
      cyc(2);
      `CHK(EVENT_FLAG, 1'b0)
      INTERVAL_COUNT <= 16'h1235;
      n = 0;
      repeat (4) begin cyc(1); n += (SPECIAL_TRIGGER !== 1'b0); end
      `CHK(n, 0)
      `CHK(EVENT_FLAG, 1'b1)
      `CHK(PIN_OWNED, 1'b0)
      end_of_test();
   end
endmodule : cpwm_unit_tb
